/* File: mfpg_checker.sv */
module mfpg_checker import mfpg_pkg::*; (
    input wire logic                   clk_i,
    input wire logic                   rstn_i,
    input wire logic                   s_axi_awready_o,
    input wire logic                   s_axi_bvalid_o,
    input wire logic                   s_axi_bready_i,
    input wire logic [1:0]             s_axi_bresp_o,
    input wire logic                   s_axi_arvalid_i,
    input wire logic                   s_axi_arready_o,
    input wire logic                   s_axi_rvalid_o,
    input wire logic                   s_axi_rready_i,
    input wire logic [31:0]            s_axi_rdata_o,
    input wire logic [7:0]             key_inputs_i,
    input wire logic                   key_wakeup_irq_o,
    input wire logic [5:0]             sport_pin_i,
    input wire mfpg_sio_in_type [1:0]  serial_in_o,
    input wire logic [4:0]             analog_pin_i,
    input wire logic                   converter_trigger_n_o,
    input wire logic [7:0]             tport_pin_oe_o,
    input wire logic [5:0]             sport_pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [3:0] up_q;

    ////////////////////////////////////////////////////////////////////
    // Cycles since release; synchronisers hold stale levels at first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            up_q <= 4'h0;
        else if (up_q != 4'hf)
            up_q <= up_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // Pins, key event and bus handshake relations
    reset_oe_a: assert property (
        up_q == 4'h1 |-> tport_pin_oe_o == 8'h00 && sport_pin_oe_o == 6'h00)
        else $error("pin driven just after reset");
    b_hold_a: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    b_done_a: assert property (
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
        else $error("write response not closed");
    r_lat_a: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h0)
        else $error("read answer late or wide");
    r_hold_a: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    key_quiet_a: assert property (
        $stable(key_inputs_i) [*8] |-> !key_wakeup_irq_o)
        else $error("key irq without key change");
    key_pulse_a: assert property (
        key_wakeup_irq_o |=> !key_wakeup_irq_o)
        else $error("key irq wider than one cycle");
    rx_follow_a: assert property (
        (up_q == 4'hf && $stable(sport_pin_i[1])) [*6] |->
        serial_in_o[0].rxd == sport_pin_i[1])
        else $error("receive data not passed");
    trig_follow_a: assert property (
        (up_q == 4'hf && $stable(analog_pin_i[3])) [*6] |->
        converter_trigger_n_o == analog_pin_i[3])
        else $error("trigger level not passed");
endmodule : mfpg_checker

/* File: mfpg_defs.svh */
`ifndef MFPG_DEFS_SVH
`define MFPG_DEFS_SVH

// Register indices; byte address is four times the index
`define MFPG_IDX_CS_DRIVE    8'h25
`define MFPG_IDX_KEY_PINS    8'h28
`define MFPG_IDX_KEY_FUNC    8'h2b
`define MFPG_IDX_TP_DATA     8'h30
`define MFPG_IDX_TP_DIR      8'h32
`define MFPG_IDX_TP_FUNC     8'h33
`define MFPG_IDX_SP_DATA     8'h3c
`define MFPG_IDX_SP_DIR      8'h3e
`define MFPG_IDX_SP_FUNC     8'h3f
`define MFPG_IDX_ANALOG_PINS 8'h40

// Bus widths
`define MFPG_AW              12
`define MFPG_DW              32

// Implemented bits of each register
`define MFPG_CS_DRIVE_MASK   8'h26
`define MFPG_TP_MASK         8'h6b
`define MFPG_SP_MASK         6'h3f
`define MFPG_SP_FUNC_MASK    6'h2d

// Reset values
`define MFPG_CS_DRIVE_RST    8'h00
`define MFPG_KEY_FUNC_RST    8'h00
`define MFPG_TP_DATA_RST     8'h6b
`define MFPG_TP_CTRL_RST     8'h00
`define MFPG_SP_DATA_RST     6'h3f
`define MFPG_SP_CTRL_RST     6'h00

// Bit positions on the timer/interrupt port
`define MFPG_TP_T0IN_BIT     0
`define MFPG_TP_T1OUT_BIT    1
`define MFPG_TP_IRQ0_BIT     3
`define MFPG_TP_T3OUT_BIT    5
`define MFPG_TP_TWOUT_BIT    6

// Bit positions on the serial port group, per channel offset
`define MFPG_SP_CH_STRIDE    3
`define MFPG_SP_TX_OFS       0
`define MFPG_SP_RX_OFS       1
`define MFPG_SP_CLK_OFS      2

// Converter trigger position on the analog port
`define MFPG_AN_TRIG_BIT     3

// AXI responses
`define MFPG_RESP_OKAY       2'h0
`define MFPG_RESP_SLVERR     2'h2

`endif

/* File: mfpg_pins_model.sv */
module mfpg_pins_model (
    input  wire logic [7:0] key_press_i,
    input  wire logic [7:0] tp_ext_i,
    input  wire logic [5:0] sp_ext_i,
    input  wire logic [7:0] tport_pin_o,
    input  wire logic [7:0] tport_pin_oe_o,
    input  wire logic [5:0] sport_pin_o,
    input  wire logic [5:0] sport_pin_oe_o,
    output logic      [7:0] key_line_o,
    output logic      [7:0] tport_line_o,
    output logic      [5:0] sport_line_o
);
    // Pull-ups hold keys high; a pressed key grounds its line
    assign key_line_o = ~key_press_i;
    // The chip wins where it drives, else the far device does
    assign tport_line_o = (tport_pin_oe_o & tport_pin_o)
                        | (~tport_pin_oe_o & tp_ext_i);
    assign sport_line_o = (sport_pin_oe_o & sport_pin_o)
                        | (~sport_pin_oe_o & sp_ext_i);
endmodule : mfpg_pins_model

/* File: mfpg_pkg.sv */
package mfpg_pkg;

    // Signals a serial core drives toward its pins
    typedef struct packed {
        logic txd;
        logic sclk;
    } mfpg_sio_out_type;

    // Signals the pins deliver to a serial core
    typedef struct packed {
        logic rxd;
        logic sclk;
        logic cts_n;
    } mfpg_sio_in_type;

    // Timer outputs that may reach the timer/interrupt port
    typedef struct packed {
        logic timer1_output;
        logic timer3_output;
        logic wide_timer_output;
    } mfpg_tmr_out_type;

endpackage : mfpg_pkg

/* File: mfpg_top.sv */
// The AXI4-Lite register port was chosen for this implementation.
`include "mfpg_defs.svh"

module mfpg_top import mfpg_pkg::*; (
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    // AXI4-Lite slave
    input  wire logic [`MFPG_AW-1:0]    s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [`MFPG_DW-1:0]    s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic [1:0]                  s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [`MFPG_AW-1:0]    s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic [`MFPG_DW-1:0]         s_axi_rdata_o,
    output logic [1:0]                  s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i,
    // Pins
    input  wire logic [7:0]             key_inputs_i,
    input  wire logic [7:0]             tport_pin_i,
    output logic      [7:0]             tport_pin_o,
    output logic      [7:0]             tport_pin_oe_o,
    input  wire logic [5:0]             sport_pin_i,
    output logic      [5:0]             sport_pin_o,
    output logic      [5:0]             sport_pin_oe_o,
    input  wire logic [4:0]             analog_pin_i,
    // Chip-select port drive mode, to that port's pad logic
    output logic      [7:0]             cs_port_open_drain_o,
    // Core side
    input  wire mfpg_tmr_out_type       timer_out_i,
    input  wire mfpg_sio_out_type [1:0] serial_out_i,
    output mfpg_sio_in_type [1:0]       serial_in_o,
    output logic                        timer0_input_o,
    output logic      [3:0]             ext_irq_o,
    output logic                        key_wakeup_irq_o,
    output logic                        converter_trigger_n_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int NSYNC = 27;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] filt_q;
    logic [7:0]       key_lvl;
    logic [7:0]       tp_lvl;
    logic [5:0]       sp_lvl;
    logic [4:0]       an_lvl;

    assign pin_raw = {analog_pin_i, sport_pin_i, tport_pin_i, key_inputs_i};

    // Three stages; a level counts once stages two and three agree.
    // Reset to 1 matches the idle level of pulled-up pins.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q   <= {NSYNC{1'b1}};
            s2_q   <= {NSYNC{1'b1}};
            s3_q   <= {NSYNC{1'b1}};
            filt_q <= {NSYNC{1'b1}};
        end else begin
            s1_q   <= pin_raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
        end
    end

    assign key_lvl = filt_q[7:0];
    assign tp_lvl  = filt_q[15:8];
    assign sp_lvl  = filt_q[21:16];
    assign an_lvl  = filt_q[26:22];

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] cs_drive_q;
    logic [7:0] key_func_q;
    logic [7:0] tp_data_q;
    logic [7:0] tp_dir_q;
    logic [7:0] tp_func_q;
    logic [5:0] sp_data_q;
    logic [5:0] sp_dir_q;
    logic [5:0] sp_func_q;
    logic       wr_fire;
    logic [7:0] wr_idx;
    logic [7:0] wr_byte;
    logic       wr_hit;
    logic       wstb_q;

    // Only byte lane 0 carries a register; other lanes are ignored
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_drive_q <= `MFPG_CS_DRIVE_RST;
            key_func_q <= `MFPG_KEY_FUNC_RST;
            tp_data_q  <= `MFPG_TP_DATA_RST;
            tp_dir_q   <= `MFPG_TP_CTRL_RST;
            tp_func_q  <= `MFPG_TP_CTRL_RST;
            sp_data_q  <= `MFPG_SP_DATA_RST;
            sp_dir_q   <= `MFPG_SP_CTRL_RST;
            sp_func_q  <= `MFPG_SP_CTRL_RST;
        end else if (wr_fire && wstb_q) begin
            case (wr_idx)
                `MFPG_IDX_CS_DRIVE: begin
                    cs_drive_q <= wr_byte & `MFPG_CS_DRIVE_MASK;
                end
                `MFPG_IDX_KEY_FUNC: begin
                    key_func_q <= wr_byte;
                end
                `MFPG_IDX_TP_DATA: begin
                    tp_data_q <= wr_byte & `MFPG_TP_MASK;
                end
                `MFPG_IDX_TP_DIR: begin
                    tp_dir_q <= wr_byte & `MFPG_TP_MASK;
                end
                `MFPG_IDX_TP_FUNC: begin
                    tp_func_q <= wr_byte & `MFPG_TP_MASK;
                end
                `MFPG_IDX_SP_DATA: begin
                    sp_data_q <= wr_byte[5:0] & `MFPG_SP_MASK;
                end
                `MFPG_IDX_SP_DIR: begin
                    sp_dir_q <= wr_byte[5:0] & `MFPG_SP_MASK;
                end
                `MFPG_IDX_SP_FUNC: begin
                    sp_func_q <= wr_byte[5:0] & `MFPG_SP_FUNC_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Address map membership; write-only and read-only both count
    function automatic logic map_hit(input logic [`MFPG_AW-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        map_hit = (a[11:10] == 2'h0) &&
                  (i == `MFPG_IDX_CS_DRIVE || i == `MFPG_IDX_KEY_PINS ||
                   i == `MFPG_IDX_KEY_FUNC || i == `MFPG_IDX_TP_DATA  ||
                   i == `MFPG_IDX_TP_DIR   || i == `MFPG_IDX_TP_FUNC  ||
                   i == `MFPG_IDX_SP_DATA  || i == `MFPG_IDX_SP_DIR   ||
                   i == `MFPG_IDX_SP_FUNC  || i == `MFPG_IDX_ANALOG_PINS);
    endfunction : map_hit

    // Read value; write-only registers read as zero, so a
    // read-modify-write would clobber them with zeros
    function automatic logic [7:0] rd_byte(input logic [7:0] i);
        rd_byte = 8'h00;
        case (i)
            `MFPG_IDX_KEY_PINS:    rd_byte = key_lvl;
            `MFPG_IDX_TP_DATA:     rd_byte = tp_lvl & `MFPG_TP_MASK;
            `MFPG_IDX_SP_DATA:     rd_byte = {2'h0, sp_lvl};
            `MFPG_IDX_ANALOG_PINS: rd_byte = {3'h0, an_lvl};
            default:               rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    logic                awready_q;
    logic                wready_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;
    logic                aw_held_q;
    logic                w_held_q;
    logic [`MFPG_AW-1:0] awaddr_q;
    logic [7:0]          wdata_q;

    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_idx  = awaddr_q[9:2];
    assign wr_byte = wdata_q;
    assign wr_hit  = map_hit(awaddr_q);

    // Address and data are taken in either order, then one write runs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `MFPG_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 8'h00;
            wstb_q    <= 1'b0;
        end else begin
            if (awready_q && s_axi_awvalid_i) begin
                awready_q <= 1'b0;
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr_i;
            end
            if (wready_q && s_axi_wvalid_i) begin
                wready_q <= 1'b0;
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata_i[7:0];
                wstb_q   <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? `MFPG_RESP_OKAY : `MFPG_RESP_SLVERR;
            end
            // Ready again only once the response is taken
            if (bvalid_q && s_axi_bready_i) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o  = wready_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    logic                arready_q;
    logic                rvalid_q;
    logic [1:0]          rresp_q;
    logic [`MFPG_DW-1:0] rdata_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `MFPG_RESP_OKAY;
            rdata_q   <= '0;
        end else begin
            if (arready_q && s_axi_arvalid_i) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= {24'h000000, rd_byte(s_axi_araddr_i[9:2])};
                rresp_q   <= map_hit(s_axi_araddr_i) ? `MFPG_RESP_OKAY
                                                     : `MFPG_RESP_SLVERR;
            end
            if (rvalid_q && s_axi_rready_i) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rresp_o   = rresp_q;
    assign s_axi_rdata_o   = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Timer/interrupt port drive

    logic [7:0] tp_out_d;
    logic [7:0] tp_oe_d;
    logic [7:0] tp_out_q;
    logic [7:0] tp_oe_q;

    // Function plus output direction hands the pin to a timer
    always_comb begin
        tp_out_d = tp_data_q;
        tp_oe_d  = tp_dir_q & `MFPG_TP_MASK;
        if (tp_func_q[`MFPG_TP_T1OUT_BIT] && tp_dir_q[`MFPG_TP_T1OUT_BIT]) begin
            tp_out_d[`MFPG_TP_T1OUT_BIT] = timer_out_i.timer1_output;
        end
        if (tp_func_q[`MFPG_TP_T3OUT_BIT] && tp_dir_q[`MFPG_TP_T3OUT_BIT]) begin
            tp_out_d[`MFPG_TP_T3OUT_BIT] = timer_out_i.timer3_output;
        end
        if (tp_func_q[`MFPG_TP_TWOUT_BIT] && tp_dir_q[`MFPG_TP_TWOUT_BIT]) begin
            tp_out_d[`MFPG_TP_TWOUT_BIT] = timer_out_i.wide_timer_output;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tp_out_q <= `MFPG_TP_DATA_RST;
            tp_oe_q  <= 8'h00;
        end else begin
            tp_out_q <= tp_out_d;
            tp_oe_q  <= tp_oe_d;
        end
    end

    assign tport_pin_o    = tp_out_q;
    assign tport_pin_oe_o = tp_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Serial port group drive

    logic [5:0] sp_out_d;
    logic [5:0] sp_oe_d;
    logic [5:0] sp_out_q;
    logic [5:0] sp_oe_q;

    // Open-drain transmit drives low only; a released pin floats high
    always_comb begin
        int tx;
        int ck;
        tx = 0;
        ck = 0;
        sp_out_d = sp_data_q;
        sp_oe_d  = sp_dir_q;
        for (int ch = 0; ch < 2; ch++) begin
            tx = ch * `MFPG_SP_CH_STRIDE + `MFPG_SP_TX_OFS;
            ck = ch * `MFPG_SP_CH_STRIDE + `MFPG_SP_CLK_OFS;
            if (sp_func_q[tx]) begin
                if (sp_dir_q[tx]) begin
                    sp_out_d[tx] = serial_out_i[ch].txd;
                    sp_oe_d[tx]  = 1'b1;
                end else begin
                    sp_out_d[tx] = 1'b0;
                    sp_oe_d[tx]  = !serial_out_i[ch].txd;
                end
            end
            if (sp_func_q[ck]) begin
                sp_out_d[ck] = serial_out_i[ch].sclk;
                sp_oe_d[ck]  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sp_out_q <= `MFPG_SP_DATA_RST;
            sp_oe_q  <= 6'h00;
        end else begin
            sp_out_q <= sp_out_d;
            sp_oe_q  <= sp_oe_d;
        end
    end

    assign sport_pin_o    = sp_out_q;
    assign sport_pin_oe_o = sp_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Inputs delivered to the cores

    mfpg_sio_in_type [1:0] sio_in_q;
    logic                  t0in_q;
    logic [3:0]            ext_irq_q;
    logic                  trig_n_q;
    logic [3:0]            irq_sel;
    logic [3:0]            irq_lvl;

    // Interrupt inputs need function set and direction input
    assign irq_sel = {tp_func_q[6] & ~tp_dir_q[6],
                      tp_func_q[5] & ~tp_dir_q[5],
                      tp_func_q[1] & ~tp_dir_q[1],
                      tp_func_q[`MFPG_TP_IRQ0_BIT] &
                      ~tp_dir_q[`MFPG_TP_IRQ0_BIT]};
    assign irq_lvl = {tp_lvl[6], tp_lvl[5], tp_lvl[1],
                      tp_lvl[`MFPG_TP_IRQ0_BIT]};

    // Receive and clock-in are fed regardless of any function bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sio_in_q  <= '1;
            t0in_q    <= 1'b0;
            ext_irq_q <= 4'h0;
            trig_n_q  <= 1'b1;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                sio_in_q[ch].rxd <=
                    sp_lvl[ch * `MFPG_SP_CH_STRIDE + `MFPG_SP_RX_OFS];
                sio_in_q[ch].sclk <=
                    sp_lvl[ch * `MFPG_SP_CH_STRIDE + `MFPG_SP_CLK_OFS];
                sio_in_q[ch].cts_n <=
                    sp_lvl[ch * `MFPG_SP_CH_STRIDE + `MFPG_SP_CLK_OFS];
            end
            t0in_q    <= tp_lvl[`MFPG_TP_T0IN_BIT] &
                         tp_func_q[`MFPG_TP_T0IN_BIT];
            ext_irq_q <= irq_lvl & irq_sel;
            trig_n_q  <= an_lvl[`MFPG_AN_TRIG_BIT];
        end
    end

    assign serial_in_o           = sio_in_q;
    assign timer0_input_o        = t0in_q;
    assign ext_irq_o             = ext_irq_q;
    assign converter_trigger_n_o = trig_n_q;
    assign cs_port_open_drain_o  = cs_drive_q;

    ////////////////////////////////////////////////////////////////////////
    // Key-on wakeup

    logic [7:0] key_prev_q;
    logic       key_irq_q;

    // Edge is taken on the filtered level, so short glitches never wake.
    // The pulse is fed to the interrupt controller, whose wake path
    // keeps running in every halt mode.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_prev_q <= 8'hff;
            key_irq_q  <= 1'b0;
        end else begin
            key_prev_q <= key_lvl;
            key_irq_q  <= |(key_prev_q & ~key_lvl & key_func_q);
        end
    end

    assign key_wakeup_irq_o = key_irq_q;

endmodule : mfpg_top

/* File: tb.sv */
module tb import mfpg_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, key_wakeup_irq_o;
    logic converter_trigger_n_o, timer0_input_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [7:0] key_inputs_i, tport_pin_i, tport_pin_o, tport_pin_oe_o;
    logic [7:0] cs_port_open_drain_o, key_press = 8'h0, tp_ext = 8'hff;
    logic [5:0] sport_pin_i, sport_pin_o, sport_pin_oe_o, sp_ext = 6'h3f;
    logic [4:0] analog_pin_i = 5'h0;
    logic [3:0] ext_irq_o;
    mfpg_tmr_out_type       timer_out_i = 3'b000;
    mfpg_sio_out_type [1:0] serial_out_i = 4'h0;
    mfpg_sio_in_type [1:0]  serial_in_o;
    int bad_count = 0;
    int samples_checked = 0;

    always #2.5 clk_i = ~clk_i;

    mfpg_top dut (.clk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .key_inputs_i,
        .tport_pin_i, .tport_pin_o, .tport_pin_oe_o, .sport_pin_i,
        .sport_pin_o, .sport_pin_oe_o, .analog_pin_i, .cs_port_open_drain_o,
        .timer_out_i, .serial_out_i, .serial_in_o, .timer0_input_o,
        .ext_irq_o, .key_wakeup_irq_o, .converter_trigger_n_o);
    mfpg_pins_model pins (.key_press_i(key_press), .tp_ext_i(tp_ext),
        .sp_ext_i(sp_ext), .tport_pin_o, .tport_pin_oe_o, .sport_pin_o,
        .sport_pin_oe_o, .key_line_o(key_inputs_i),
        .tport_line_o(tport_pin_i), .sport_line_o(sport_pin_i));

    ////////////////////////////////////////////////////////////////////
    // Compare, bus cycles and waits
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // Ready comes late, so the slave must hold its answer
    task automatic wr(input logic [7:0] i, d, input logic [1:0] r = 2'h0);
        int n = 0;
        @(posedge clk_i);
        s_axi_awaddr_i <= {2'h0, i, 2'h0};
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (n == 3) s_axi_bready_i <= 1'b1;
        end while (!(s_axi_bvalid_o && s_axi_bready_i) && n < 50);
        s_axi_bready_i <= 1'b0;
        chk({s_axi_bvalid_o, s_axi_bresp_o}, {1'b1, r});
    endtask : wr
    task automatic rd(input logic [7:0] i, d, input logic [1:0] r = 2'h0);
        int n = 0;
        @(posedge clk_i);
        s_axi_araddr_i <= {2'h0, i, 2'h0};
        s_axi_arvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (n == 2) s_axi_rready_i <= 1'b1;
        end while (!(s_axi_rvalid_o && s_axi_rready_i) && n < 50);
        s_axi_rready_i <= 1'b0;
        chk({s_axi_rvalid_o, s_axi_rresp_o}, {1'b1, r});
        if (r == 2'h0) chk(s_axi_rdata_o, {24'h0, d});
    endtask : rd
    task automatic irq_count(input int exp);
        int c = 0;
        repeat (12) begin
            @(posedge clk_i);
            c += int'(key_wakeup_irq_o === 1'b1);
        end
        chk(c, exp);
    endtask : irq_count

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_regs();
        chk({tport_pin_oe_o, tport_pin_o}, 16'h006b);
        chk({sport_pin_oe_o, sport_pin_o}, 12'h03f);
        rd(8'h2b, 8'h00);
        rd(8'h28, 8'hff);
        rd(8'h01, 8'h00, 2'h2);
        wr(8'h01, 8'hff, 2'h2);
        wr(8'h28, 8'h00);
        wr(8'h25, 8'hff);
        cyc(2);
        chk(cs_port_open_drain_o, 8'h26);
        rd(8'h25, 8'h00);
    endtask : t_reset_regs
    task automatic t_keys();
        key_press <= 8'h20;
        irq_count(0);
        rd(8'h28, 8'hdf);
        key_press <= 8'h00;
        wr(8'h2b, 8'hff);
        for (int i = 0; i < 8; i++) begin
            key_press <= 8'h01 << i;
            irq_count(1);
            key_press <= 8'h00;
            irq_count(0);
        end
        wr(8'h2b, 8'hdf);
        key_press <= 8'h20;
        irq_count(0);
    endtask : t_keys
    task automatic t_tport();
        wr(8'h30, 8'h00);
        cyc(6);
        rd(8'h30, 8'h6b);
        wr(8'h32, 8'h6b);
        cyc(2);
        chk({tport_pin_oe_o, tport_pin_o}, 16'h6b00);
        tp_ext <= 8'h29;
        wr(8'h32, 8'h00);
        wr(8'h33, 8'h6b);
        cyc(6);
        chk({timer0_input_o, ext_irq_o}, 5'h15);
        timer_out_i <= 3'b101;
        wr(8'h32, 8'h62);
        cyc(3);
        chk(tport_pin_oe_o & 8'h62, 8'h62);
        chk(tport_pin_o & 8'h62, 8'h42);
        chk(ext_irq_o, 4'h1);
    endtask : t_tport
    task automatic t_sport();
        serial_out_i <= 4'b0110;
        wr(8'h3f, 8'h2d);
        cyc(2);
        chk({sport_pin_oe_o, sport_pin_o & 6'h2d}, 12'hb20);
        wr(8'h3e, 8'h09);
        cyc(2);
        chk({sport_pin_oe_o, sport_pin_o & 6'h2d}, 12'hb61);
        sp_ext <= 6'h14;
        wr(8'h3f, 8'h00);
        wr(8'h3e, 8'h00);
        cyc(6);
        chk(serial_in_o, 6'h23);
        rd(8'h3c, 8'h14);
    endtask : t_sport
    task automatic t_analog();
        analog_pin_i <= 5'h08;
        cyc(6);
        chk(converter_trigger_n_o, 1'b1);
        rd(8'h40, 8'h08);
        analog_pin_i <= 5'h17;
        cyc(6);
        chk(converter_trigger_n_o, 1'b0);
        rd(8'h40, 8'h17);
    endtask : t_analog
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////
    // Main run, then a watchdog some twenty times the expected length
    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_reset_regs();
        t_keys();
        t_tport();
        t_sport();
        t_analog();
        conclude();
    end
    initial begin
        #40us;
        bad_count++;
        conclude();
    end
endmodule : tb

bind mfpg_top mfpg_checker u_chk (.clk_i, .rstn_i, .s_axi_awready_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
    .key_inputs_i, .key_wakeup_irq_o, .sport_pin_i, .serial_in_o,
    .analog_pin_i, .converter_trigger_n_o, .tport_pin_oe_o, .sport_pin_oe_o);
